// ===== tsm_serial_map_map.vh
// Address, field and timing constants of the serial memory map block.
`ifndef TSM_SERIAL_MAP_MAP_VH
`define TSM_SERIAL_MAP_MAP_VH
// Seven-bit device addresses of the two maps.
`define TSM_DEV_ID 7'h50
`define TSM_DEV_DIAG 7'h51
// Serial-ID map regions.
`define TSM_ID_VENDOR_LO 8'h60
`define TSM_ID_VENDOR_HI 8'h7f
// Diagnostic map regions.
`define TSM_THR_HI 8'h27
`define TSM_CAL_LO 8'h38
`define TSM_CAL_HI 8'h5b
`define TSM_CHECKSUM 8'h5f
`define TSM_ANALOG_LO 8'h60
`define TSM_ANALOG_HI 8'h69
`define TSM_CTRL_STATUS 8'h6e
`define TSM_RATE_CTRL 8'h6f
`define TSM_ALARM_HI 8'h70
`define TSM_ALARM_LO 8'h71
`define TSM_WARN_HI 8'h74
`define TSM_WARN_LO 8'h75
`define TSM_EXT_CTRL 8'h76
`define TSM_PW_LO 8'h78
`define TSM_PW_HI 8'h7e
`define TSM_SCR_LO 8'h80
`define TSM_SCR_HI 8'hf7
`define TSM_AMASK_HI 8'hf8
`define TSM_AMASK_LO 8'hf9
`define TSM_WMASK_HI 8'hfa
`define TSM_WMASK_LO 8'hfb
`define TSM_USER_CTRL 8'hfe
`define TSM_RESET_CTRL 8'hff
// Field positions.
`define TSM_SOFT_RATE_BIT 3
`define TSM_CFG5_PW_SEL 2
`define TSM_CFG3_RST_EN 7
`define TSM_RST_FIRE 3'h7
// Timing: clock rate and printed times.
`define TSM_CLK_MHZ 25
`define TSM_T_PULSE_US 125
`define TSM_T_CLEAR_MS_X10 225
`define TSM_T_WR_MS 13
`define TSM_PULSE_CYC (`TSM_T_PULSE_US * `TSM_CLK_MHZ)
`define TSM_CLEAR_CYC (`TSM_T_CLEAR_MS_X10 * 100 * `TSM_CLK_MHZ)
`define TSM_WR_CYC (`TSM_T_WR_MS * 1000 * `TSM_CLK_MHZ)
`endif

// ===== tsm_serial_map.v
// Serial-ID and diagnostic memory maps with their access gating.
//
// Notes on behaviour
// [RULE_01] Map A0h: ID bytes 0-95, vendor 96-127, reserved 128-255.
// [RULE_02] ID bytes 0-95 are read and written only under a valid password.
// [RULE_03] Upper 128 ID bytes are NVRAM reachable only under valid password.
// [RULE_04] Thresholds 00h-27h are written only with password, else read-only.
// [RULE_05] Calibration 38h-5Bh written only with password, else read-only.
// [RULE_06] Checksum byte 5Fh written only with password, else read-only.
// [RULE_07] Host never writes reserved locations and ignores what they read.
// [RULE_08] Ten bytes of live analog data appear at 60h-69h.
// [RULE_09] Rate control bits 7-6 choose between pins and software rate bits.
// [RULE_10] Alarm flags 70h-71h are read-only; writes are ignored.
// [RULE_11] Warning flags 74h-75h are read-only; writes are ignored.
// [RULE_12] Password window at 78h-7Bh, or 7Bh-7Eh when config five bit 2 set.
// [RULE_13] Scratchpad 80h-F7h is writable without any password.
// [RULE_14] Alarm mask bit set hides its alarm; cleared leaves it visible.
// [RULE_15] Warning mask bit set hides its warning; cleared leaves it visible.
// [RULE_16] With config three bit 7 set, reset byte bits 2-0 steer reset pin.
// [RULE_17] Writing 111 while enabled drives a 125 us low reset pulse.
// [RULE_18] Bits 2-0 clear 22.5 ms after the pulse ends.
// [RULE_19] During a nonvolatile write cycle every transaction is refused.
// [RULE_20] Protected writes without valid password leave contents unchanged.
`timescale 1ns/100ps
`include "tsm_serial_map_map.vh"
module tsm_serial_map #(
  parameter WR_CYCLES = `TSM_WR_CYC,
  parameter CLEAR_CYCLES = `TSM_CLEAR_CYC
) (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Byte access port from the serial protocol engine.
  input wire req_in,
  input wire we_in,
  input wire [6:0] dev_addr_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire txn_end_in,
  output reg [7:0] rdata_out,
  output reg ack_out,
  output reg nack_out,
  output reg nv_busy_out,
  // Live device state.
  input wire [79:0] analog_in,
  input wire [15:0] alarm_in,
  input wire [15:0] warning_in,
  input wire [31:0] password_set_in,
  input wire [7:0] oem_config_three_in,
  input wire [7:0] oem_config_five_in,
  // Pins and summaries.
  input wire rate_sel_pin_lo_in,
  input wire rate_sel_pin_hi_in,
  output reg [1:0] rate_sel_out,
  output reg alarm_active_out,
  output reg warning_active_out,
  output reg reset_output_pin_out
);

  localparam PULSE_CYCLES = `TSM_PULSE_CYC;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PULSE = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  reg [7:0] id_mem [0:255];
  reg [7:0] diag_mem [0:255];
  reg [1:0] rs_meta_reg;
  reg [1:0] rs_sync_reg;
  reg [7:0] ctrl_status_reg;
  reg [7:0] rate_ctrl_reg;
  reg [7:0] ext_ctrl_reg;
  reg [7:0] user_ctrl_reg;
  reg [7:0] reset_ctrl_reg;
  reg [15:0] alarm_mask_reg;
  reg [15:0] warn_mask_reg;
  reg [55:0] pw_field_reg;
  reg nv_dirty_reg;
  reg [18:0] busy_cnt_reg;
  reg [1:0] rst_state_reg;
  reg [19:0] rst_cnt_reg;
  reg [7:0] rd_next;
  reg [1:0] rate_next;
  wire [7:0] analog_byte [0:9];
  wire go;
  wire is_id;
  wire is_diag;
  wire pw_ok;
  wire id_open;
  wire diag_prot;
  wire diag_scr;
  wire wr_id;
  wire wr_diag;
  wire wr_reset_ctrl;
  wire [3:0] pw_idx;

  // Analog bytes, most significant byte at the lowest offset.
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_analog
      assign analog_byte[gi] = analog_in[79 - 8 * gi -: 8];
    end
  endgenerate

  // Address decode of the access port.
  assign go = req_in & ~nv_busy_out; // RULE_19
  assign is_id = dev_addr_in == `TSM_DEV_ID; // RULE_01
  assign is_diag = dev_addr_in == `TSM_DEV_DIAG;
  assign id_open = (addr_in >= `TSM_ID_VENDOR_LO) &&
                   (addr_in <= `TSM_ID_VENDOR_HI); // RULE_01
  assign diag_prot = (addr_in <= `TSM_THR_HI) || // RULE_04
                     ((addr_in >= `TSM_CAL_LO) &&
                      (addr_in <= `TSM_CAL_HI)) || // RULE_05
                     (addr_in == `TSM_CHECKSUM); // RULE_06
  assign diag_scr = (addr_in >= `TSM_SCR_LO) &&
                    (addr_in <= `TSM_SCR_HI); // RULE_13
  assign pw_idx = addr_in[3:0] - 4'h8;

  // The password compare picks its four bytes from the seven-byte field.
  assign pw_ok = oem_config_five_in[`TSM_CFG5_PW_SEL] ?
                 (pw_field_reg[31:0] == password_set_in) :
                 (pw_field_reg[55:24] == password_set_in); // RULE_12

  // Protected stores require the password; otherwise they are dropped.
  assign wr_id = go & we_in & is_id & (pw_ok | id_open); // RULE_02 RULE_03
  assign wr_diag = go & we_in & is_diag &
                   ((diag_prot & pw_ok) | diag_scr); // RULE_20 RULE_13
  assign wr_reset_ctrl = go & we_in & is_diag &
                         (addr_in == `TSM_RESET_CTRL);

  // Read multiplexer; reserved diagnostic bytes read zero.
  always @* begin
    rd_next = 8'h00;
    if (is_id) begin
      if (pw_ok || id_open) begin
        rd_next = id_mem[addr_in]; // RULE_02 RULE_03
      end
    end else if (diag_prot || diag_scr) begin
      rd_next = diag_mem[addr_in];
    end else if ((addr_in >= `TSM_ANALOG_LO) &&
                 (addr_in <= `TSM_ANALOG_HI)) begin
      rd_next = analog_byte[addr_in[3:0]]; // RULE_08
    end else if (addr_in == `TSM_CTRL_STATUS) begin
      rd_next = {2'h0, rs_sync_reg[0], rs_sync_reg[1],
                 ctrl_status_reg[3], 3'h0};
    end else if (addr_in == `TSM_RATE_CTRL) begin
      rd_next = rate_ctrl_reg;
    end else if (addr_in == `TSM_ALARM_HI) begin
      rd_next = alarm_in[15:8]; // RULE_10
    end else if (addr_in == `TSM_ALARM_LO) begin
      rd_next = alarm_in[7:0]; // RULE_10
    end else if (addr_in == `TSM_WARN_HI) begin
      rd_next = warning_in[15:8]; // RULE_11
    end else if (addr_in == `TSM_WARN_LO) begin
      rd_next = warning_in[7:0]; // RULE_11
    end else if (addr_in == `TSM_EXT_CTRL) begin
      rd_next = {4'h0, ext_ctrl_reg[3], 3'h0};
    end else if (addr_in == `TSM_AMASK_HI) begin
      rd_next = alarm_mask_reg[15:8];
    end else if (addr_in == `TSM_AMASK_LO) begin
      rd_next = alarm_mask_reg[7:0];
    end else if (addr_in == `TSM_WMASK_HI) begin
      rd_next = warn_mask_reg[15:8];
    end else if (addr_in == `TSM_WMASK_LO) begin
      rd_next = warn_mask_reg[7:0];
    end else if (addr_in == `TSM_USER_CTRL) begin
      rd_next = user_ctrl_reg;
    end else if (addr_in == `TSM_RESET_CTRL) begin
      rd_next = reset_ctrl_reg;
    end
  end

  // Nonvolatile arrays carry no reset; they model stored contents.
  always @(posedge clk_in) begin
    if (wr_id) begin
      id_mem[addr_in] <= wdata_in;
    end
    if (wr_diag) begin
      diag_mem[addr_in] <= wdata_in;
    end
  end

  // Two-stage synchroniser for the rate select pins.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rs_meta_reg <= 2'h0;
      rs_sync_reg <= 2'h0;
    end else begin
      rs_meta_reg <= {rate_sel_pin_hi_in, rate_sel_pin_lo_in};
      rs_sync_reg <= rs_meta_reg;
    end
  end

  // Rate select source: 00 pins, 01 soft bits, 10 either, 11 pins.
  always @* begin
    case (rate_ctrl_reg[7:6]) // RULE_09
      2'h1: rate_next = {ext_ctrl_reg[`TSM_SOFT_RATE_BIT],
                         ctrl_status_reg[`TSM_SOFT_RATE_BIT]};
      2'h2: rate_next = rs_sync_reg |
                        {ext_ctrl_reg[`TSM_SOFT_RATE_BIT],
                         ctrl_status_reg[`TSM_SOFT_RATE_BIT]};
      default: rate_next = rs_sync_reg;
    endcase
  end

  // Answer, volatile registers and masked summaries.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
      ack_out <= 1'b0;
      nack_out <= 1'b0;
      ctrl_status_reg <= 8'h00;
      rate_ctrl_reg <= 8'h00;
      ext_ctrl_reg <= 8'h00;
      user_ctrl_reg <= 8'h00;
      alarm_mask_reg <= 16'h0000;
      warn_mask_reg <= 16'h0000;
      pw_field_reg <= 56'h0;
      rate_sel_out <= 2'h0;
      alarm_active_out <= 1'b0;
      warning_active_out <= 1'b0;
    end else begin
      // Unknown device addresses and a busy array both get a refusal.
      ack_out <= go & (is_id | is_diag);
      nack_out <= req_in & ~(go & (is_id | is_diag)); // RULE_19
      // A refused read leaves the last answered byte in place.
      if (go & ~we_in & (is_id | is_diag)) begin
        rdata_out <= rd_next;
      end
      if (go & we_in & is_diag) begin
        // Flags and analog data have no storage, so writes fall away.
        if (addr_in == `TSM_CTRL_STATUS) begin
          ctrl_status_reg <= wdata_in & 8'h08;
        end else if (addr_in == `TSM_RATE_CTRL) begin
          rate_ctrl_reg <= wdata_in;
        end else if (addr_in == `TSM_EXT_CTRL) begin
          ext_ctrl_reg <= wdata_in & 8'h08;
        end else if ((addr_in >= `TSM_PW_LO) &&
                     (addr_in <= `TSM_PW_HI)) begin
          pw_field_reg[55 - 8 * pw_idx -: 8] <= wdata_in; // RULE_12
        end else if (addr_in == `TSM_AMASK_HI) begin
          alarm_mask_reg[15:8] <= wdata_in;
        end else if (addr_in == `TSM_AMASK_LO) begin
          alarm_mask_reg[7:0] <= wdata_in;
        end else if (addr_in == `TSM_WMASK_HI) begin
          warn_mask_reg[15:8] <= wdata_in;
        end else if (addr_in == `TSM_WMASK_LO) begin
          warn_mask_reg[7:0] <= wdata_in;
        end else if (addr_in == `TSM_USER_CTRL) begin
          user_ctrl_reg <= wdata_in;
        end
      end
      rate_sel_out <= rate_next; // RULE_09
      alarm_active_out <= |(alarm_in & ~alarm_mask_reg); // RULE_14
      warning_active_out <= |(warning_in & ~warn_mask_reg); // RULE_15
    end
  end

  // Write cycle timer starts at the end of a transaction that stored NV data.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nv_dirty_reg <= 1'b0;
      busy_cnt_reg <= 19'h0;
      nv_busy_out <= 1'b0;
    end else begin
      if (txn_end_in) begin
        nv_dirty_reg <= 1'b0;
        if (nv_dirty_reg | wr_id | wr_diag) begin
          nv_busy_out <= 1'b1; // RULE_19
          busy_cnt_reg <= 19'h0;
        end
      end else if (wr_id | wr_diag) begin
        nv_dirty_reg <= 1'b1;
      end
      if (nv_busy_out && !txn_end_in) begin
        if (busy_cnt_reg == WR_CYCLES[18:0] - 19'h1) begin
          nv_busy_out <= 1'b0;
        end else begin
          busy_cnt_reg <= busy_cnt_reg + 19'h1;
        end
      end
    end
  end

  // Reset pulse sequencer; a host write wins over the timed clear.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_ctrl_reg <= 8'h00;
      rst_state_reg <= ST_IDLE;
      rst_cnt_reg <= 20'h0;
      reset_output_pin_out <= 1'b1;
    end else begin
      case (rst_state_reg)
        ST_IDLE: begin
          reset_output_pin_out <= 1'b1;
          if (wr_reset_ctrl &&
              oem_config_three_in[`TSM_CFG3_RST_EN] &&
              wdata_in[2:0] == `TSM_RST_FIRE) begin // RULE_16
            rst_state_reg <= ST_PULSE;
            rst_cnt_reg <= 20'h0;
            reset_output_pin_out <= 1'b0; // RULE_17
          end
        end
        ST_PULSE: begin
          if (rst_cnt_reg == PULSE_CYCLES[19:0] - 20'h1) begin
            rst_state_reg <= ST_HOLD;
            rst_cnt_reg <= 20'h0;
            reset_output_pin_out <= 1'b1;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 20'h1;
          end
        end
        ST_HOLD: begin
          if (rst_cnt_reg == CLEAR_CYCLES[19:0] - 20'h1) begin
            rst_state_reg <= ST_IDLE;
            rst_cnt_reg <= 20'h0;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 20'h1;
          end
        end
        default: begin
          rst_state_reg <= ST_IDLE;
        end
      endcase
      if (wr_reset_ctrl) begin
        reset_ctrl_reg <= wdata_in;
      end else if (rst_state_reg == ST_HOLD &&
                   rst_cnt_reg == CLEAR_CYCLES[19:0] - 20'h1) begin
        reset_ctrl_reg[2:0] <= 3'h0; // RULE_18
      end
    end
  end

endmodule

// ===== tsm_serial_map_asserts.sv
// Concurrent checks on the ports of the serial memory map block.
`timescale 1ns/100ps
module tsm_serial_map_asserts (
  // Clock, reset and access port.
  input wire clk_in,
  input wire arst_n_in,
  input wire req_in,
  input wire we_in,
  input wire [6:0] dev_addr_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  input wire ack_out,
  input wire nack_out,
  input wire nv_busy_out,
  // Live state and reset pin.
  input wire [15:0] alarm_in,
  input wire [15:0] warning_in,
  input wire [7:0] oem_config_three_in,
  input wire reset_output_pin_out
);
  wire dev_ok = dev_addr_in == 7'h50 || dev_addr_in == 7'h51;
  wire rd_diag = req_in && !we_in && dev_addr_in == 7'h51 && !nv_busy_out;
  reg [11:0] low_cnt_reg;
  reg [7:0] alarm_hi_reg;
  reg [7:0] warn_lo_reg;
  reg fire_reg;
  // Helper state: flag bytes and fire request one cycle late, and the
  // length of the current low pulse, which is too long for a repetition.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt_reg <= 12'h000;
      alarm_hi_reg <= 8'h00;
      warn_lo_reg <= 8'h00;
      fire_reg <= 1'b0;
    end else begin
      low_cnt_reg <= reset_output_pin_out ? 12'h000 : low_cnt_reg + 12'h001;
      alarm_hi_reg <= alarm_in[15:8];
      warn_lo_reg <= warning_in[7:0];
      fire_reg <= req_in && we_in && dev_addr_in == 7'h51 &&
        addr_in == 8'hff && wdata_in[2:0] == 3'h7 && oem_config_three_in[7];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_req_answered: assert property (req_in && dev_ok &&
    !nv_busy_out |=> ack_out && !nack_out)
    else $error("Accepted request not acked.");
  a_bad_device: assert property (req_in && !dev_ok |=>
    nack_out && !ack_out) else $error("Foreign address not refused.");
  a_busy_refused: assert property (req_in && nv_busy_out |=>
    nack_out && !ack_out) else $error("Request during write cycle acked.");
  a_no_spurious: assert property (!req_in |=> !ack_out && !nack_out)
    else $error("Answer without request.");
  a_busy_holds: assert property ($rose(nv_busy_out) |->
    nv_busy_out [*8]) else $error("Write cycle ended too soon.");
  a_alarm_read: assert property (rd_diag && addr_in == 8'h70 |=>
    rdata_out == alarm_hi_reg) else $error("Alarm byte read wrong.");
  a_warn_read: assert property (rd_diag && addr_in == 8'h75 |=>
    rdata_out == warn_lo_reg) else $error("Warning byte read wrong.");
  a_pulse_cause: assert property ($fell(reset_output_pin_out) |->
    fire_reg) else $error("Reset pulse without enabled fire write.");
  a_pulse_len: assert property ($rose(reset_output_pin_out) |->
    low_cnt_reg == 12'hc35) else $error("Reset pulse length wrong.");
endmodule

// ===== tsm_host_model.sv
// Behavioural host that issues byte accesses to the map block.
`timescale 1ns/100ps
module tsm_host_model (
  // Clock and answers from the block.
  input wire clk_in,
  input wire ack_in,
  input wire nack_in,
  input wire nv_busy_in,
  input wire [7:0] rdata_in,
  // Request lines.
  output reg req_out = 1'b0,
  output reg we_out = 1'b0,
  output reg [6:0] dev_out = 7'h00,
  output reg [7:0] addr_out = 8'h00,
  output reg [7:0] wdata_out = 8'h00,
  output reg txn_end_out = 1'b0
);
  integer n;
  // One byte access. Qualifiers are inverted once released, so a block
  // that samples them late sees garbage rather than a stale match.
  // Callers only write mapped places, never reserved ones.
  task acc(input w, input [6:0] dv, input [7:0] a, input [7:0] d,
           output ok, output bad, output [7:0] q);
    begin
      @(posedge clk_in);
      req_out <= 1'b1;
      we_out <= w;
      dev_out <= dv;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      req_out <= 1'b0;
      we_out <= ~w;
      dev_out <= ~dv;
      addr_out <= ~a;
      wdata_out <= ~d;
      #1;
      ok = ack_in;
      bad = nack_in;
      q = rdata_in;
    end
  endtask
  // Bus stop; a stored nonvolatile byte starts its write cycle here.
  task stop;
    begin
      @(posedge clk_in);
      txn_end_out <= 1'b1;
      @(posedge clk_in);
      txn_end_out <= 1'b0;
    end
  endtask
  // Bounded wait for a write cycle to end.
  task idle;
    begin
      repeat (3) @(posedge clk_in);
      #1;
      for (n = 0; n < 200 && nv_busy_in !== 1'b0; n = n + 1)
        @(posedge clk_in) #1;
    end
  endtask
endmodule

// ===== tsm_serial_map_bench.sv
// Self-checking bench for the serial memory map block.
`timescale 1ns/100ps
module tsm_serial_map_bench;
  localparam [79:0] ANA = {8'hc1, 64'h0, 8'he9};
  localparam [31:0] PW = 32'h13579bdf;
  // Rows: write flag, device, offset, write byte, expected read byte.
  localparam [0:28][31:0] ROWS = {
    32'h50000000, 32'h50800000,
    32'hd1803c00, 32'h5180003c,
    32'hd170ff00, 32'h517000a5, 32'h5171001e,
    32'hd1750000, 32'h5174003c, 32'h5175007d,
    32'h516000c1, 32'h516900e9,
    32'hd1781300, 32'hd1795700, 32'hd17a9b00, 32'hd17bdf00,
    32'hd0004400, 32'h50000044,
    32'hd1002200, 32'hd1382300, 32'hd15f2400, 32'hd1780000,
    32'hd1001100, 32'h51000022, 32'hd1381100, 32'h51380023,
    32'hd15f1100, 32'h515f0024, 32'h50000000};
  reg clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg lclk = 1'b0;
  reg pin_lo = 1'b0;
  reg pin_hi = 1'b0;
  reg [7:0] cfg3 = 8'h00;
  reg [7:0] cfg5 = 8'h00;
  reg ok, bad;
  reg [7:0] q;
  reg [31:0] r;
  integer failures = 0;
  integer cmp_count = 0;
  integer i;
  wire req, we, txn, ack, nack, busy, aact, wact, rpin;
  wire [6:0] dev;
  wire [7:0] addr, wdata, rdata;
  wire [1:0] rsel;
  // System clock, and a slower unrelated link clock that moves the pins.
  always #20 clk_in = ~clk_in;
  always #160 lclk = ~lclk;
  always @(posedge clk_in) begin
    pin_hi <= lclk;
    pin_lo <= ~lclk;
  end
  tsm_host_model hst (.clk_in(clk_in), .ack_in(ack), .nack_in(nack),
    .nv_busy_in(busy), .rdata_in(rdata), .req_out(req), .we_out(we),
    .dev_out(dev), .addr_out(addr), .wdata_out(wdata), .txn_end_out(txn));
  // Short write and clear cycles keep the run brief.
  tsm_serial_map #(.WR_CYCLES(20), .CLEAR_CYCLES(30)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req), .we_in(we),
    .dev_addr_in(dev), .addr_in(addr), .wdata_in(wdata), .txn_end_in(txn),
    .rdata_out(rdata), .ack_out(ack), .nack_out(nack), .nv_busy_out(busy),
    .analog_in(ANA), .alarm_in(16'ha51e), .warning_in(16'h3c7d),
    .password_set_in(PW), .oem_config_three_in(cfg3),
    .oem_config_five_in(cfg5), .rate_sel_pin_lo_in(pin_lo),
    .rate_sel_pin_hi_in(pin_hi), .rate_sel_out(rsel),
    .alarm_active_out(aact), .warning_active_out(wact),
    .reset_output_pin_out(rpin));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    hst.acc(1'b1, 7'h51, a, d, ok, bad, q);
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // A hang is cut short well after the expected run of some 3.5k cycles.
  initial begin
    #2000000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (i = 0; i < 29; i = i + 1) begin
      r = ROWS[i];
      hst.acc(r[31], r[30:24], r[23:16], r[15:8], ok, bad, q);
      chk({7'h0, ok}, 8'h01);
      if (r[31]) begin
        hst.stop;
        hst.idle;
      end else
        chk(q, r[7:0]);
    end
    $display("table rows done");
    wr(8'h81, 8'h5a);
    hst.stop;
    hst.acc(1'b0, 7'h51, 8'h80, 8'h00, ok, bad, q);
    chk({7'h0, bad}, 8'h01);
    chk({7'h0, busy}, 8'h01);
    hst.idle;
    hst.acc(1'b0, 7'h52, 8'h00, 8'h00, ok, bad, q);
    chk({7'h0, bad}, 8'h01);
    chk({7'h0, aact}, 8'h01);
    wr(8'hf8, 8'hff);
    wr(8'hf9, 8'hff);
    wr(8'hfa, 8'hff);
    repeat (3) @(posedge clk_in);
    chk({6'h0, wact, aact}, 8'h02);
    wr(8'hfb, 8'hff);
    wr(8'h6f, 8'h40);
    wr(8'h6e, 8'h08);
    repeat (3) @(posedge clk_in);
    chk({5'h0, wact, rsel}, 8'h01);
    // The bench pins are always opposite, so pin mode shows one bit set.
    wr(8'h6f, 8'h00);
    repeat (3) @(posedge clk_in);
    chk({7'h0, ^rsel}, 8'h01);
    wr(8'h6f, 8'h80);
    repeat (3) @(posedge clk_in);
    chk({7'h0, rsel[0]}, 8'h01);
    $display("refusal, mask and rate tests done");
    @(posedge clk_in) cfg5 <= 8'h04;
    for (i = 0; i < 4; i = i + 1)
      wr(8'h7b + i[7:0], PW[31 - 8 * i -: 8]);
    wr(8'h00, 8'h66);
    hst.stop;
    hst.idle;
    hst.acc(1'b0, 7'h51, 8'h00, 8'h00, ok, bad, q);
    chk(q, 8'h66);
    @(posedge clk_in) cfg3 <= 8'h80;
    wr(8'hff, 8'h07);
    @(posedge clk_in) #1;
    chk({7'h0, rpin}, 8'h00);
    for (i = 0; i < 4000 && rpin !== 1'b1; i = i + 1)
      @(posedge clk_in) #1;
    // The count starts one cycle into the 3125-cycle pulse.
    chk({7'h0, rpin}, 8'h01);
    chk({7'h0, i == 3124}, 8'h01);
    hst.acc(1'b0, 7'h51, 8'hff, 8'h00, ok, bad, q);
    chk(q & 8'h07, 8'h07);
    repeat (40) @(posedge clk_in);
    hst.acc(1'b0, 7'h51, 8'hff, 8'h00, ok, bad, q);
    chk(q & 8'h07, 8'h00);
    @(posedge clk_in) cfg3 <= 8'h00;
    wr(8'hff, 8'h07);
    repeat (3) @(posedge clk_in);
    chk({7'h0, rpin}, 8'h01);
    $display("window and reset pin tests done");
    @(posedge clk_in) arst_n_in <= 1'b0;
    @(posedge clk_in) #1;
    chk({4'h0, rsel, aact, rpin}, 8'h01);
    arst_n_in <= 1'b1;
    hst.acc(1'b0, 7'h51, 8'h6f, 8'h00, ok, bad, q);
    chk({7'h0, ok}, 8'h01);
    chk(q, 8'h00);
    $display("reset test done");
    print_verdict;
  end
endmodule
bind tsm_serial_map tsm_serial_map_asserts chk_i (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .req_in(req_in), .we_in(we_in),
  .dev_addr_in(dev_addr_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .ack_out(ack_out), .nack_out(nack_out),
  .nv_busy_out(nv_busy_out), .alarm_in(alarm_in), .warning_in(warning_in),
  .oem_config_three_in(oem_config_three_in),
  .reset_output_pin_out(reset_output_pin_out));
